// [ralc_afe_model.sv]
// Purpose: analog front end model for ralc_top
// Assumes: eye peaks at one boost value
// Notes: calibration done after fixed hold
`include "ralc_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module ralc_afe_model (
	input  wire logic       clk,
	input  wire logic [7:0] boost,
	input  wire logic       cal_req,
	input  wire logic [7:0] peak,
	input  wire logic       eye_bad,
	output wire logic       cal_done,
	output wire logic       pll_locked,
	output wire logic [7:0] h_eye,
	output wire logic [7:0] v_eye
);
	int cnt = 0;
	always @(posedge clk) begin
		cnt <= cal_req ? cnt + 1 : 0;
	end
	assign cal_done   = cal_req && cnt >= `RALC_CAL_CYC;
	assign pll_locked = !cal_req;
	assign h_eye      = eye_bad ? 8'h40 : (boost == peak ? 8'hF0 : 8'h90);
	assign v_eye      = h_eye;
endmodule // ralc_afe_model
`default_nettype wire

// [ralc_consts.vh]
// Purpose: constants for the retimer adaptation and lock control block
// Assumes: 8-bit registers at printed channel offsets
// Notes: timing counts in 10 MHz core clock cycles
`ifndef RALC_CONSTS_VH
`define RALC_CONSTS_VH
`define RALC_A_RST      8'h00
`define RALC_A_BOOST    8'h03
`define RALC_A_DFETRIG  8'h24
`define RALC_A_LOOK     8'h2C
`define RALC_A_RATE     8'h2F
`define RALC_A_MODE     8'h31
`define RALC_A_CFGA     8'h33
`define RALC_A_LIMA     8'h34
`define RALC_A_LIMB     8'h35
`define RALC_A_REFM     8'h36
`define RALC_A_SIDX     8'h39
`define RALC_A_EYEM     8'h3E
`define RALC_A_TBL      8'h40
`define RALC_A_THR      8'h6A
`define RALC_B_CHRST    2
`define RALC_B_DFEGO    2
`define RALC_B_CTLEGO   0
`define RALC_B_SIDXOV   3
`define RALC_B_EYEM     7
`define RALC_D_LOOK     8'h02
`define RALC_D_RATE     8'h00
`define RALC_D_MODE     8'h20
`define RALC_D_CFGA     8'h00
`define RALC_D_LIMA     8'h0F
`define RALC_D_LIMB     8'h1F
`define RALC_D_REFM     8'h00
`define RALC_D_SIDX     8'h00
`define RALC_D_EYEM     8'h80
`define RALC_D_THR      8'h88
`define RALC_REFM_OK    2'b11
`define RALC_CAL_NS     1000
`define RALC_CLK_NS     100
`define RALC_CAL_CYC    ((`RALC_CAL_NS + `RALC_CLK_NS - 1) / `RALC_CLK_NS)
`endif

// [ralc_props.sv]
// Purpose: port checks for ralc_top
// Assumes: shadow registers follow register writes
// Notes: single clock domain
`include "ralc_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module ralc_props (
	input wire logic       CORE_CLK,
	input wire logic       RST,
	input wire logic       REG_WR,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic [7:0] HORIZONTAL_EYE_OPENING,
	input wire logic [7:0] VERTICAL_EYE_OPENING,
	input wire logic       PLL_LOCKED,
	input wire logic       REF_FREQ_OK,
	input wire logic       SPUR_LOCK,
	input wire logic [4:0] DFE_TAP1,
	input wire logic [3:0] DFE_TAPN,
	input wire logic       DFE_ENABLE,
	input wire logic [3:0] VCO_FREQ_SET,
	input wire logic       VCO_CAL_REQ,
	input wire logic       LOCK,
	input wire logic       LOSS_IRQ
);
	// --------
	// shadows
	// --------
	logic [7:0] mode_r, thr_r, eyem_r, rate_r;
	wire        chrst = REG_WR && REG_ADDR == `RALC_A_RST && REG_WDATA[`RALC_B_CHRST];
	wire  [7:0] h_min = {thr_r[7:4], 4'h0};
	wire  [7:0] v_min = {thr_r[3:0], 4'h0};
	always @(posedge CORE_CLK) begin
		if (RST || chrst) begin
			mode_r <= `RALC_D_MODE;
			thr_r  <= `RALC_D_THR;
			eyem_r <= `RALC_D_EYEM;
			rate_r <= `RALC_D_RATE;
		end else if (REG_WR) begin
			if (REG_ADDR == `RALC_A_MODE) mode_r <= REG_WDATA;
			if (REG_ADDR == `RALC_A_THR) thr_r <= REG_WDATA;
			if (REG_ADDR == `RALC_A_EYEM) eyem_r <= REG_WDATA;
			if (REG_ADDR == `RALC_A_RATE) rate_r <= REG_WDATA;
		end
	end
	// --------
	// checks
	// --------
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	sequence eye_low;
		LOCK && eyem_r[7] && (HORIZONTAL_EYE_OPENING < h_min || VERTICAL_EYE_OPENING < v_min);
	endsequence
	sequence mon_off_hold;
		LOCK && !eyem_r[7] && PLL_LOCKED && REF_FREQ_OK && !SPUR_LOCK && !REG_WR &&
		!$past(REG_WR, 2);
	endsequence
	cal_after_rst_a: assert property ($fell(RST) |-> VCO_CAL_REQ)
		else $error("no vco calibration after reset");
	lock_on_eye_a: assert property ($rose(LOCK) |->
		$past(HORIZONTAL_EYE_OPENING) > h_min && $past(VERTICAL_EYE_OPENING) > v_min)
		else $error("lock with small eye");
	eye_loss_a: assert property (eye_low |-> ##[1:4] !LOCK)
		else $error("lock kept with small eye");
	monitor_off_a: assert property (mon_off_hold |=> LOCK)
		else $error("lock lost with monitor off");
	irq_pulse_a: assert property (LOSS_IRQ |=> !LOSS_IRQ)
		else $error("loss pulse too long");
	irq_cause_a: assert property (LOSS_IRQ |-> !LOCK && ($past(LOCK) || $past(LOCK, 2)))
		else $error("loss pulse without lock loss");
	mode_one_zero_a: assert property (mode_r[6:5] == 2'b01 && $stable(mode_r) |->
		DFE_TAP1 == 5'h00 && DFE_TAPN == 4'h0 && DFE_ENABLE)
		else $error("taps not zero in ctle mode");
	dfe_enable_a: assert property (DFE_ENABLE == (mode_r[6:5] != 2'b00))
		else $error("dfe enable wrong for mode");
	vco_set_a: assert property (VCO_FREQ_SET == rate_r[7:4])
		else $error("vco set differs from rate");
endmodule // ralc_props
bind ralc_top ralc_props i_ralc_props (.CORE_CLK, .RST, .REG_WR, .REG_ADDR, .REG_WDATA,
	.HORIZONTAL_EYE_OPENING, .VERTICAL_EYE_OPENING, .PLL_LOCKED, .REF_FREQ_OK, .SPUR_LOCK, .DFE_TAP1,
	.DFE_TAPN, .DFE_ENABLE, .VCO_FREQ_SET, .VCO_CAL_REQ, .LOCK, .LOSS_IRQ);
`default_nettype wire

// [ralc_top.v]
// Purpose: per-channel adaptation, lock qualification and eye monitor control
// Assumes: register port is a simple synchronous read/write strobe interface
// Notes: analog measurements arrive as plain synchronous inputs
`include "ralc_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module ralc_top #(
	parameter TBL_DEPTH = 32
) (
	input  wire       CORE_CLK,
	input  wire       RST,
	input  wire       REG_WR,
	input  wire       REG_RD,
	input  wire [7:0] REG_ADDR,
	input  wire [7:0] REG_WDATA,
	output reg  [7:0] REG_RDATA,
	input  wire       PLL_LOCKED,
	input  wire       REF_FREQ_OK,
	input  wire       SPUR_LOCK,
	input  wire       CAL_DONE,
	input  wire [7:0] HORIZONTAL_EYE_OPENING,
	input  wire [7:0] VERTICAL_EYE_OPENING,
	input  wire [4:0] DFE_TAP1_REQ,
	input  wire [3:0] DFE_TAPN_REQ,
	output reg  [7:0] CTLE_BOOST,
	output reg  [4:0] DFE_TAP1,
	output reg  [3:0] DFE_TAPN,
	output wire       DFE_ENABLE,
	output reg        DFE_ADAPT_ACTIVE,
	output wire [3:0] VCO_FREQ_SET,
	output reg        VCO_CAL_REQ,
	output reg        LOCK,
	output reg        LOSS_IRQ
);
	// ------------------------------------------------------------
	// states
	// ------------------------------------------------------------
	localparam [8:0] S_CAL   = 9'h001;
	localparam [8:0] S_IDLE  = 9'h002;
	localparam [8:0] S_APPLY = 9'h004;
	localparam [8:0] S_MEAS  = 9'h008;
	localparam [8:0] S_NEXT  = 9'h010;
	localparam [8:0] S_DONE  = 9'h020;
	localparam [8:0] S_DFE   = 9'h040;
	localparam [8:0] S_LOCK  = 9'h080;
	localparam [8:0] S_ACQ   = 9'h100;
	localparam integer CAL_CYC = `RALC_CAL_CYC;

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	reg [7:0] boost_r;
	reg [7:0] look_r;
	reg [7:0] rate_r;
	reg [7:0] mode_r;
	reg [7:0] cfga_r;
	reg [7:0] lima_r;
	reg [7:0] limb_r;
	reg [7:0] refm_r;
	reg [7:0] sidx_r;
	reg [7:0] eyem_r;
	reg [7:0] thr_r;
	reg [7:0] dfetrig_r;
	reg [7:0] tbl_r [0:TBL_DEPTH-1];
	reg [8:0] st_r;
	reg [4:0] idx_r;
	reg [4:0] best_idx_r;
	reg [7:0] best_fom_r;
	reg [3:0] beyond_r;
	reg       have_best_r;
	reg [1:0] pass_r;
	reg [7:0] cnt_r;
	reg       ctle_go_d_r;
	reg       dfe_go_d_r;
	reg       ctle_req_r;
	reg       dfe_req_r;
	integer   i;

	wire       chrst    = REG_WR && (REG_ADDR == `RALC_A_RST) && REG_WDATA[`RALC_B_CHRST];
	wire       rst_all  = RST || chrst;
	wire [1:0] mode     = mode_r[6:5];
	wire       tbl_hit  = (REG_ADDR >= `RALC_A_TBL) && (REG_ADDR < `RALC_A_TBL + TBL_DEPTH);
	wire [4:0] tbl_ix   = REG_ADDR[4:0];

	// ------------------------------------------------------------
	// table defaults
	// ------------------------------------------------------------
	function [7:0] tbl_def;
		input [4:0] k;
		begin
			case (k)
				5'h00:   tbl_def = 8'h00;
				5'h01:   tbl_def = 8'h01;
				5'h02:   tbl_def = 8'h04;
				5'h03:   tbl_def = 8'h10;
				5'h04:   tbl_def = 8'h40;
				5'h05:   tbl_def = 8'h08;
				5'h06:   tbl_def = 8'h02;
				5'h07:   tbl_def = 8'h80;
				5'h08:   tbl_def = 8'h03;
				5'h09:   tbl_def = 8'h0C;
				5'h0A:   tbl_def = 8'h30;
				5'h0B:   tbl_def = 8'h41;
				5'h0C:   tbl_def = 8'h50;
				5'h0D:   tbl_def = 8'hC0;
				5'h0E:   tbl_def = 8'h60;
				5'h0F:   tbl_def = 8'h90;
				5'h10:   tbl_def = 8'h88;
				5'h11:   tbl_def = 8'h82;
				5'h12:   tbl_def = 8'hA0;
				5'h13:   tbl_def = 8'h46;
				5'h14:   tbl_def = 8'h52;
				5'h15:   tbl_def = 8'h8C;
				5'h16:   tbl_def = 8'hB0;
				5'h17:   tbl_def = 8'hC8;
				5'h18:   tbl_def = 8'h57;
				5'h19:   tbl_def = 8'h5D;
				5'h1A:   tbl_def = 8'h69;
				5'h1B:   tbl_def = 8'h75;
				5'h1C:   tbl_def = 8'hD5;
				5'h1D:   tbl_def = 8'h99;
				5'h1E:   tbl_def = 8'h96;
				5'h1F:   tbl_def = 8'hA5;
				default: tbl_def = 8'h00;
			endcase
		end
	endfunction

	// eye merit: min of horizontal and scaled vertical
	function [7:0] fom;
		input [7:0] h;
		input [7:0] v;
		reg   [7:0] vs;
		begin
			vs  = {1'b0, v[7:1]};
			fom = (h < vs) ? h : vs;
		end
	endfunction

	wire [7:0] cur_fom  = fom(HORIZONTAL_EYE_OPENING, VERTICAL_EYE_OPENING);
	wire       eye_ok   = (HORIZONTAL_EYE_OPENING > {thr_r[7:4], 4'h0}) &&
	                      (VERTICAL_EYE_OPENING > {thr_r[3:0], 4'h0});
	wire       ctle_go  = rate_r[`RALC_B_CTLEGO];
	wire       dfe_go   = dfetrig_r[`RALC_B_DFEGO];
	wire [4:0] start_ix = rate_r[`RALC_B_SIDXOV] ? sidx_r[4:0] : 5'd0;

	assign VCO_FREQ_SET = {rate_r[7:6], rate_r[5:4]};
	assign DFE_ENABLE   = (mode != 2'b00);

	// ------------------------------------------------------------
	// register file
	// ------------------------------------------------------------
	always @(posedge CORE_CLK) begin
		if (rst_all) begin
			look_r    <= `RALC_D_LOOK;
			rate_r    <= `RALC_D_RATE;
			mode_r    <= `RALC_D_MODE;
			cfga_r    <= `RALC_D_CFGA;
			lima_r    <= `RALC_D_LIMA;
			limb_r    <= `RALC_D_LIMB;
			refm_r    <= `RALC_D_REFM;
			sidx_r    <= `RALC_D_SIDX;
			eyem_r    <= `RALC_D_EYEM;
			thr_r     <= `RALC_D_THR;
			dfetrig_r <= 8'h00;
			for (i = 0; i < TBL_DEPTH; i = i + 1) begin
				tbl_r[i] <= tbl_def(i[4:0]);
			end
		end else if (REG_WR) begin
			case (REG_ADDR)
				`RALC_A_LOOK:    look_r    <= REG_WDATA;
				`RALC_A_RATE:    rate_r    <= REG_WDATA;
				`RALC_A_MODE:    mode_r    <= REG_WDATA;
				`RALC_A_CFGA:    cfga_r    <= REG_WDATA;
				`RALC_A_LIMA:    lima_r    <= REG_WDATA;
				`RALC_A_LIMB:    limb_r    <= REG_WDATA;
				`RALC_A_REFM:    refm_r    <= REG_WDATA;
				`RALC_A_SIDX:    sidx_r    <= REG_WDATA;
				`RALC_A_EYEM:    eyem_r    <= REG_WDATA;
				`RALC_A_THR:     thr_r     <= REG_WDATA;
				`RALC_A_DFETRIG: dfetrig_r <= REG_WDATA;
				default: begin
					if (tbl_hit) begin
						tbl_r[tbl_ix] <= REG_WDATA;
					end
				end
			endcase
		end
	end

	always @(posedge CORE_CLK) begin
		if (RST) begin
			REG_RDATA <= 8'h00;
		end else if (REG_RD) begin
			case (REG_ADDR)
				`RALC_A_RST:     REG_RDATA <= 8'h00;
				`RALC_A_BOOST:   REG_RDATA <= boost_r;
				`RALC_A_LOOK:    REG_RDATA <= look_r;
				`RALC_A_RATE:    REG_RDATA <= rate_r;
				`RALC_A_MODE:    REG_RDATA <= mode_r;
				`RALC_A_CFGA:    REG_RDATA <= cfga_r;
				`RALC_A_LIMA:    REG_RDATA <= lima_r;
				`RALC_A_LIMB:    REG_RDATA <= limb_r;
				`RALC_A_REFM:    REG_RDATA <= refm_r;
				`RALC_A_SIDX:    REG_RDATA <= sidx_r;
				`RALC_A_EYEM:    REG_RDATA <= eyem_r;
				`RALC_A_THR:     REG_RDATA <= thr_r;
				`RALC_A_DFETRIG: REG_RDATA <= dfetrig_r;
				default:         REG_RDATA <= tbl_hit ? tbl_r[tbl_ix] : 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------
	// manual triggers
	// ------------------------------------------------------------
	always @(posedge CORE_CLK) begin
		if (rst_all) begin
			ctle_go_d_r <= 1'b0;
			dfe_go_d_r  <= 1'b0;
			ctle_req_r  <= 1'b0;
			dfe_req_r   <= 1'b0;
		end else begin
			ctle_go_d_r <= ctle_go;
			dfe_go_d_r  <= dfe_go;
			// set wins over clear on acceptance
			if (ctle_go && !ctle_go_d_r) begin
				ctle_req_r <= 1'b1;
			end else if (st_r == S_IDLE) begin
				ctle_req_r <= 1'b0;
			end
			// dfe request kept until the dfe step runs
			if (dfe_go && !dfe_go_d_r) begin
				dfe_req_r <= 1'b1;
			end else if (st_r == S_DFE) begin
				dfe_req_r <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// adaptation and lock sequencer
	// ------------------------------------------------------------
	always @(posedge CORE_CLK) begin
		if (rst_all) begin
			st_r             <= S_CAL;
			idx_r            <= 5'd0;
			best_idx_r       <= 5'd0;
			best_fom_r       <= 8'h00;
			beyond_r         <= 4'd0;
			have_best_r      <= 1'b0;
			pass_r           <= 2'd0;
			cnt_r            <= 8'd0;
			boost_r          <= 8'h00;
			CTLE_BOOST       <= 8'h00;
			DFE_TAP1         <= 5'd0;
			DFE_TAPN         <= 4'd0;
			DFE_ADAPT_ACTIVE <= 1'b0;
			VCO_CAL_REQ      <= 1'b1;
			LOCK             <= 1'b0;
			LOSS_IRQ         <= 1'b0;
		end else begin
			LOSS_IRQ <= 1'b0;
			case (st_r)
				S_CAL: begin
					VCO_CAL_REQ <= 1'b1;
					if (cnt_r < CAL_CYC) begin
						cnt_r <= cnt_r + 8'd1;
					end else if (CAL_DONE && refm_r[5:4] == `RALC_REFM_OK) begin
						VCO_CAL_REQ <= 1'b0;
						cnt_r       <= 8'd0;
						st_r        <= S_IDLE;
					end
				end
				S_IDLE: begin
					pass_r      <= 2'd0;
					have_best_r <= 1'b0;
					beyond_r    <= 4'd0;
					idx_r       <= start_ix;
					if (ctle_req_r || (mode != 2'b00)) begin
						st_r <= S_APPLY;
					end else if (dfe_req_r) begin
						st_r <= S_DFE;
					end else begin
						st_r <= S_ACQ;
					end
				end
				S_ACQ: begin
					if (PLL_LOCKED && eye_ok) begin
						LOCK <= 1'b1;
						st_r <= S_LOCK;
					end else if (ctle_req_r || dfe_req_r || mode != 2'b00) begin
						st_r <= S_IDLE;
					end
				end
				S_APPLY: begin
					CTLE_BOOST <= tbl_r[idx_r];
					if (mode != 2'b10 && mode != 2'b11) begin
						DFE_TAP1 <= 5'd0;
						DFE_TAPN <= 4'd0;
					end
					st_r <= S_MEAS;
				end
				S_MEAS: begin
					if (PLL_LOCKED && cur_fom > best_fom_r || PLL_LOCKED && !have_best_r) begin
						best_fom_r  <= cur_fom;
						best_idx_r  <= idx_r;
						have_best_r <= 1'b1;
						beyond_r    <= 4'd0;
					end else if (have_best_r) begin
						beyond_r <= beyond_r + 4'd1;
					end
					if (mode == 2'b11 && pass_r == 2'd0 && PLL_LOCKED && eye_ok) begin
						best_idx_r <= idx_r;
						st_r       <= S_DONE;
					end else begin
						st_r <= S_NEXT;
					end
				end
				S_NEXT: begin
					if (idx_r == TBL_DEPTH - 1 || (have_best_r && beyond_r > look_r[3:0])) begin
						st_r <= S_DONE;
					end else begin
						idx_r <= idx_r + 5'd1;
						st_r  <= S_APPLY;
					end
				end
				S_DONE: begin
					CTLE_BOOST <= tbl_r[best_idx_r];
					boost_r    <= tbl_r[best_idx_r];
					if ((mode == 2'b10 || mode == 2'b11 || dfe_req_r) && pass_r == 2'd0) begin
						st_r <= S_DFE;
					end else begin
						st_r <= S_ACQ;
					end
				end
				S_DFE: begin
					DFE_ADAPT_ACTIVE <= 1'b1;
					DFE_TAP1 <= (DFE_TAP1_REQ > limb_r[4:0]) ? limb_r[4:0] : DFE_TAP1_REQ;
					DFE_TAPN <= (DFE_TAPN_REQ > lima_r[3:0]) ? lima_r[3:0] : DFE_TAPN_REQ;
					if (mode == 2'b10 || mode == 2'b11) begin
						pass_r      <= 2'd1;
						have_best_r <= 1'b0;
						beyond_r    <= 4'd0;
						idx_r       <= start_ix;
						st_r        <= S_APPLY;
					end else begin
						st_r <= S_ACQ;
					end
					if (pass_r != 2'd0) begin
						st_r <= S_ACQ;
					end
				end
				S_LOCK: begin
					DFE_ADAPT_ACTIVE <= 1'b0;
					if (SPUR_LOCK) begin
						LOCK <= 1'b0;
						st_r <= S_IDLE;
					end else if (!PLL_LOCKED || !REF_FREQ_OK ||
					             (eyem_r[`RALC_B_EYEM] && !eye_ok)) begin
						LOCK     <= 1'b0;
						LOSS_IRQ <= 1'b1;
						st_r     <= S_IDLE;
					end else if (ctle_req_r || dfe_req_r) begin
						LOCK <= 1'b0;
						st_r <= S_IDLE;
					end
				end
				default: st_r <= S_IDLE;
			endcase
			// ctle-only mode holds taps at zero
			if (mode == 2'b01) begin
				DFE_TAP1 <= 5'd0;
				DFE_TAPN <= 4'd0;
			end
		end
	end
endmodule // ralc_top
`default_nettype wire

// [ralc_top_test.sv]
// Purpose: self-checking bench for ralc_top
// Assumes: front end model supplies eye and calibration
// Notes: registers reached by strobe tasks
`include "ralc_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module ralc_top_test;
	logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, spur = 1'b0, bad = 1'b0;
	logic       refok = 1'b1;
	logic [7:0] addr = 8'h00, wd = 8'h00, peak = 8'h10;
	logic [4:0] t1q = 5'h00;
	logic [3:0] tnq = 4'h0;
	wire  [7:0] rdat, boost, he, ve;
	wire  [4:0] tap1;
	wire  [3:0] tapn, vset;
	wire        cdone, pll, den, dact, calq, lock, irq;
	int         n_mismatch = 0, samples_checked = 0, cyc = 0, nirq = 0;
	always #50 clk = ~clk;
	ralc_top i_ralc_top (.CORE_CLK(clk), .RST(rst), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
		.REG_WDATA(wd), .REG_RDATA(rdat), .PLL_LOCKED(pll), .REF_FREQ_OK(refok),
		.SPUR_LOCK(spur), .CAL_DONE(cdone), .HORIZONTAL_EYE_OPENING(he),
		.VERTICAL_EYE_OPENING(ve), .DFE_TAP1_REQ(t1q), .DFE_TAPN_REQ(tnq), .CTLE_BOOST(boost),
		.DFE_TAP1(tap1), .DFE_TAPN(tapn), .DFE_ENABLE(den), .DFE_ADAPT_ACTIVE(dact),
		.VCO_FREQ_SET(vset), .VCO_CAL_REQ(calq), .LOCK(lock), .LOSS_IRQ(irq));
	ralc_afe_model i_ralc_afe_model (.clk(clk), .boost(boost), .cal_req(calq), .peak(peak),
		.eye_bad(bad), .cal_done(cdone), .pll_locked(pll), .h_eye(he), .v_eye(ve));
	// --------
	// helpers
	// --------
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (irq === 1'b1) nirq++;
		if (cyc == 90000) begin
			n_mismatch++;
			give_verdict;
		end
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		{wr, addr, wd} = {1'b1, a, d};
		@(negedge clk);
		wr = 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		{rd, addr} = {1'b1, a};
		@(negedge clk);
		rd = 1'b0;
		d = rdat;
	endtask
	task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd_reg(a, d);
		chk(d, e);
	endtask
	task automatic wait_reg(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		for (int i = 0; i < 1000; i++) begin
			rd_reg(a, d);
			if (d === e) break;
		end
		chk(d, e);
	endtask
	task automatic wait_lock(input logic e);
		for (int i = 0; i < 3000 && lock !== e; i++) @(negedge clk);
		chk({7'h0, lock}, {7'h0, e});
	endtask
	// --------
	// tests
	// --------
	task automatic t_reset;
		chk({7'h0, calq}, 8'h01);
		chk_reg(`RALC_A_LOOK, `RALC_D_LOOK);
		chk_reg(`RALC_A_MODE, `RALC_D_MODE);
		chk_reg(`RALC_A_THR, `RALC_D_THR);
		chk_reg(`RALC_A_EYEM, `RALC_D_EYEM);
		chk_reg(8'h44, 8'h40);
		chk_reg(8'h10, 8'h00);
		$display("test reset done");
	endtask
	task automatic t_table;
		wr_reg(8'h45, 8'h5A);
		chk_reg(8'h45, 8'h5A);
		wr_reg(`RALC_A_RST, 8'h04);
		chk_reg(8'h45, 8'h08);
		$display("test table done");
	endtask
	task automatic t_lock;
		int n;
		wr_reg(`RALC_A_REFM, 8'h30);
		wait_lock(1'b1);
		wait_reg(`RALC_A_BOOST, 8'h10);
		n = nirq;
		bad = 1'b1;
		wait_lock(1'b0);
		repeat (3) @(negedge clk);
		chk(8'(nirq - n), 8'h01);
		bad = 1'b0;
		wait_lock(1'b1);
		wr_reg(`RALC_A_EYEM, 8'h00);
		bad = 1'b1;
		repeat (50) @(negedge clk);
		chk({7'h0, lock}, 8'h01);
		bad = 1'b0;
		wr_reg(`RALC_A_EYEM, 8'h80);
		$display("test lock done");
	endtask
	task automatic t_manual;
		wr_reg(`RALC_A_SIDX, 8'h05);
		wr_reg(`RALC_A_RATE, 8'hB8);
		chk({4'h0, vset}, 8'h0B);
		wr_reg(`RALC_A_RATE, 8'hB9);
		wr_reg(`RALC_A_RATE, 8'hB8);
		wait_reg(`RALC_A_BOOST, 8'h08);
		wr_reg(8'h46, 8'h10);
		wr_reg(`RALC_A_RATE, 8'hB9);
		wr_reg(`RALC_A_RATE, 8'hB8);
		wait_reg(`RALC_A_BOOST, 8'h10);
		chk(boost, 8'h10);
		$display("test manual done");
	endtask
	task automatic t_dfe;
		t1q = 5'h1F;
		tnq = 4'hF;
		for (int m = 0; m < 4; m++) begin
			wr_reg(`RALC_A_MODE, 8'(m << 5));
			@(negedge clk);
			chk({7'h0, den}, {7'h0, m != 0});
		end
		wr_reg(`RALC_A_MODE, 8'h20);
		repeat (3) @(negedge clk);
		chk({3'h0, tap1}, 8'h00);
		chk({7'h0, den}, 8'h01);
		wr_reg(`RALC_A_LIMA, 8'h03);
		wr_reg(`RALC_A_LIMB, 8'h05);
		wr_reg(`RALC_A_MODE, 8'h40);
		wr_reg(`RALC_A_DFETRIG, 8'h04);
		wr_reg(`RALC_A_DFETRIG, 8'h00);
		for (int i = 0; i < 500 && dact !== 1'b1; i++) @(negedge clk);
		chk({7'h0, dact}, 8'h01);
		repeat (2) @(negedge clk);
		chk({3'h0, tap1}, 8'h05);
		chk({4'h0, tapn}, 8'h03);
		$display("test dfe done");
	endtask
	task automatic t_spur;
		int n;
		wr_reg(`RALC_A_MODE, 8'h20);
		wait_lock(1'b1);
		repeat (3) @(negedge clk);
		chk({3'h0, tap1}, 8'h00);
		chk({4'h0, tapn}, 8'h00);
		spur = 1'b1;
		wait_lock(1'b0);
		spur = 1'b0;
		wait_lock(1'b1);
		n = nirq;
		refok = 1'b0;
		wait_lock(1'b0);
		refok = 1'b1;
		repeat (2) @(negedge clk);
		chk(8'(nirq - n), 8'h01);
		wait_lock(1'b1);
		$display("test spur done");
	endtask
	initial begin
		repeat (10) @(negedge clk);
		rst = 1'b0;
		t_reset;
		t_table;
		t_lock;
		t_manual;
		t_dfe;
		t_spur;
		give_verdict;
	end
endmodule // ralc_top_test
`default_nettype wire
